//--- hw/pmrs_pkg.sv
// constants and types of the power mode and reset sequencer
package pmrs_pkg;

   // ==========================================
   // register map, byte addresses
   localparam logic [7:0] ADR_CTRL    = 8'h00;
   localparam logic [7:0] ADR_STOPDIS = 8'h04;
   localparam logic [7:0] ADR_CLKCFG  = 8'h08;
   localparam logic [7:0] ADR_STATUS  = 8'h0c;

   // ==========================================
   // field positions
   localparam int CTRL_SWRST = 0;
   localparam int CTRL_HSCLK = 1;
   localparam int CFG_SRC    = 0;
   localparam int CFG_PLL_POWER_DOWN  = 1;
   localparam int CFG_OSCSB  = 2;
   localparam int CFG_REGSB  = 3;
   localparam int CFG_OSCPD  = 4;
   localparam int CFG_EXTSB  = 5;
   localparam int CFG_W      = 6;
   localparam int ST_MODE    = 0;
   localparam int ST_STBY    = 2;
   localparam int ST_CGRST   = 3;
   localparam int ST_PERRST  = 4;
   localparam int ST_CORERST = 5;
   localparam int ST_CAUSE   = 8;
   localparam int CAUSE_POR  = 0;
   localparam int CAUSE_EXT  = 1;
   localparam int CAUSE_WDOG = 2;
   localparam int CAUSE_SW   = 3;
   localparam int NPER       = 8;

   // ==========================================
   // timing counts, in ticks of the named clock
   localparam logic [6:0] POR_EXT_OSC   = 7'h40;
   localparam logic [6:0] CG_EXT_OSC    = 7'h20;
   localparam logic [6:0] SYNC_HOLD_OSC = 7'h03;
   localparam logic [6:0] PER_EXT_SYS   = 7'h20;
   localparam logic [6:0] CORE_EXT_SYS  = 7'h20;
   localparam logic [9:0] WDOG_DIV_M1   = 10'h3ff;

   // ==========================================
   // types
   typedef enum logic [1:0] {
      MODE_RUN   = 2'b00,
      MODE_WAIT  = 2'b01,
      MODE_STOP  = 2'b10,
      MODE_PDOWN = 2'b11
   } pmrs_mode_e;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } pmrs_wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } pmrs_wb_rsp_s;

   typedef struct packed {
      pmrs_mode_e        mode;
      logic              por;
      logic [6:0]        por_cnt;
      logic              ext_por;
      logic [6:0]        cg_cnt;
      logic              cg_rst;
      logic [6:0]        sy_cnt;
      logic              sy_hold;
      logic [6:0]        per_cnt;
      logic              per_rst;
      logic [6:0]        core_cnt;
      logic              core_rst;
      logic              sw_req;
      logic [9:0]        wd_cnt;
      logic              wd_tick;
      logic              mst_ph;
      logic              sys_tick;
      logic              hs_sel;
      logic [NPER-1:0]   stop_dis;
      logic [CFG_W-1:0]  cfg;
      logic [3:0]        cause;
      logic              ack;
      logic [31:0]       rdat;
   } pmrs_state_s;

   localparam pmrs_state_s STATE_RST = '{
      mode: MODE_RUN, por: 1'b1, ext_por: 1'b1,
      cg_rst: 1'b1, sy_hold: 1'b1, per_rst: 1'b1,
      core_rst: 1'b1, default: '0};

endpackage

//--- hw/pmrs_top.sv
// power mode clock gating and staged reset sequencer
// How it works
// - four modes; run enables every clock
// - wait instruction stops core and memory
// - interrupt, debug or reset ends wait
// - stop instruction gates core, memory and peripheral clocks; master clock runs
// - stop ends on stop-irq, lvi, debug, reset
// - stop-disable bit keeps peripheral clock running
// - wait or stop allowed inside standby
// - standby external 400kHz halved to 200kHz
// - power-down stops all, reset only recovery
// - watchdog ticks at oscillator over 1024
// - peripherals on system clock, optional 3x
// - five sources, two async, three sync
// - test port reset only from power-on
// - power-on stretched 64 oscillator ticks
// - clock-gen reset releases 32 osc later
// - peripheral reset 32 system ticks later
// - core reset 32 system ticks later
// - early stretch counts on oscillator ticks
// - sw/watchdog logic held 3 osc ticks
// - core runs only after core reset
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module pmrs_top
   import pmrs_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   ce_i,
   input  wire pmrs_pkg::pmrs_wb_req_s wb_req_i,
   output pmrs_pkg::pmrs_wb_rsp_s      wb_rsp_o,
   input  wire logic                   osc_tick_i,
   input  wire logic                   mst_tick_i,
   input  wire logic                   ext_tick_i,
   input  wire logic                   por_i,
   input  wire logic                   ext_rst_i,
   input  wire logic                   wdog_timeout_i,
   input  wire logic                   clock_loss_i,
   input  wire logic                   wait_instr_i,
   input  wire logic                   stop_instr_i,
   input  wire logic                   irq_any_i,
   input  wire logic                   stop_irq_i,
   input  wire logic                   lvi_irq_i,
   input  wire logic                   debug_entry_i,
   output logic                        sys_tick_o,
   output logic                        wdog_tick_o,
   output logic                        master_clk_en_o,
   output logic                        core_clk_en_o,
   output logic                        mem_clk_en_o,
   output logic [pmrs_pkg::NPER-1:0]   periph_clk_en_o,
   output logic                        hs_clk_en_o,
   output logic                        clock_source_select_o,
   output logic                        pll_power_down_o,
   output logic                        osc_standby_select_o,
   output logic                        regulator_standby_o,
   output logic                        osc_power_down_o,
   output logic                        clock_gen_reset_out_o,
   output logic                        peripheral_reset_out_o,
   output logic                        core_reset_o,
   output logic                        tap_reset_o,
   output logic                        wdog_logic_reset_o,
   output pmrs_pkg::pmrs_mode_e        mode_o,
   output logic                        standby_o
);
   import pmrs_pkg::*;

   // ==========================================
   // state
   pmrs_state_s s_q;
   pmrs_state_s s_d;

   logic combined;
   logic sync_src;
   logic standby;
   logic bus_go;
   logic bus_wr;
   logic clk_src_tick;
   logic periph_on;

   // ==========================================
   // combined reset and standby decode
   always_comb begin
      // sync sources are ignored while held; power-down has no clock for them
      sync_src = ~s_q.sy_hold & (s_q.mode != MODE_PDOWN) &
                 (wdog_timeout_i | clock_loss_i | s_q.sw_req);
      combined = por_i | s_q.ext_por | ext_rst_i | sync_src;
      // standby is a software-built clock setup, the block only decodes it
      standby  = s_q.cfg[CFG_SRC] & s_q.cfg[CFG_PLL_POWER_DOWN] &
                 s_q.cfg[CFG_OSCSB] & s_q.cfg[CFG_REGSB];
      bus_go   = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
      bus_wr   = bus_go & wb_req_i.we & wb_req_i.sel[0];
      // external standby clock replaces master ticks when chosen
      clk_src_tick = (standby & s_q.cfg[CFG_EXTSB]) ?
                     ext_tick_i : mst_tick_i;
   end

   // ==========================================
   // next state
   always_comb begin
      s_d = s_q;

      // raw power-on level, also the test port reset
      s_d.por = por_i;

      // power-on extender, oscillator time base
      if (por_i) begin
         s_d.ext_por = 1'b1;
         s_d.por_cnt = '0;
      end else if (s_q.ext_por & osc_tick_i) begin
         if (s_q.por_cnt == POR_EXT_OSC - 7'h01) begin
            s_d.ext_por = 1'b0;
         end else begin
            s_d.por_cnt = s_q.por_cnt + 7'h01;
         end
      end

      // clock-gen extender restarts on any source
      if (combined) begin
         s_d.cg_rst = 1'b1;
         s_d.cg_cnt = '0;
      end else if (s_q.cg_rst & osc_tick_i) begin
         if (s_q.cg_cnt == CG_EXT_OSC - 7'h01) begin
            s_d.cg_rst = 1'b0;
         end else begin
            s_d.cg_cnt = s_q.cg_cnt + 7'h01;
         end
      end

      // short hold of software and watchdog reset logic
      if (combined) begin
         s_d.sy_hold = 1'b1;
         s_d.sy_cnt  = '0;
      end else if (s_q.sy_hold & osc_tick_i) begin
         if (s_q.sy_cnt == SYNC_HOLD_OSC - 7'h01) begin
            s_d.sy_hold = 1'b0;
         end else begin
            s_d.sy_cnt = s_q.sy_cnt + 7'h01;
         end
      end

      // system tick: master tick, or external tick in standby, halved; stopped while clock gen resets
      if (s_q.cg_rst | combined) begin
         s_d.mst_ph   = 1'b0;
         s_d.sys_tick = 1'b0;
      end else begin
         s_d.sys_tick = 1'b0;
         if (clk_src_tick & (s_q.mode != MODE_PDOWN)) begin
            s_d.mst_ph   = ~s_q.mst_ph;
            s_d.sys_tick = s_q.mst_ph;
         end
      end

      // peripheral extender on system ticks
      if (combined | s_q.cg_rst) begin
         s_d.per_rst = 1'b1;
         s_d.per_cnt = '0;
      end else if (s_q.per_rst & s_q.sys_tick) begin
         if (s_q.per_cnt == PER_EXT_SYS - 7'h01) begin
            s_d.per_rst = 1'b0;
         end else begin
            s_d.per_cnt = s_q.per_cnt + 7'h01;
         end
      end

      // core extender on system ticks
      if (combined | s_q.per_rst) begin
         s_d.core_rst = 1'b1;
         s_d.core_cnt = '0;
      end else if (s_q.core_rst & s_q.sys_tick) begin
         if (s_q.core_cnt == CORE_EXT_SYS - 7'h01) begin
            s_d.core_rst = 1'b0;
         end else begin
            s_d.core_cnt = s_q.core_cnt + 7'h01;
         end
      end

      // watchdog time base, oscillator over 1024
      s_d.wd_tick = 1'b0;
      if (osc_tick_i) begin
         if (s_q.wd_cnt == WDOG_DIV_M1) begin
            s_d.wd_cnt  = '0;
            s_d.wd_tick = 1'b1;
         end else begin
            s_d.wd_cnt = s_q.wd_cnt + 10'h001;
         end
      end

      // power mode machine; instructions count only once core runs
      if (combined) begin
         s_d.mode = MODE_RUN;
      end else begin
         unique case (s_q.mode)
            MODE_RUN: begin
               if (~s_q.core_rst) begin
                  if (standby & s_q.cfg[CFG_OSCPD]) begin
                     s_d.mode = MODE_PDOWN;
                  end else if (stop_instr_i) begin
                     s_d.mode = MODE_STOP;
                  end else if (wait_instr_i) begin
                     s_d.mode = MODE_WAIT;
                  end
               end
            end
            MODE_WAIT: begin
               if (irq_any_i | debug_entry_i) begin
                  s_d.mode = MODE_RUN;
               end
            end
            MODE_STOP: begin
               if (stop_irq_i | lvi_irq_i | debug_entry_i) begin
                  s_d.mode = MODE_RUN;
               end
            end
            MODE_PDOWN: begin
               // left only through a reset source
               s_d.mode = MODE_PDOWN;
            end
         endcase
      end

      // software reset request, cleared once it enters combined
      if (combined) begin
         s_d.sw_req = 1'b0;
      end

      // reset cause, sticky; a new cause beats the clear
      if (bus_wr & (wb_req_i.adr == ADR_STATUS) & wb_req_i.sel[1]) begin
         s_d.cause = s_q.cause &
                     ~wb_req_i.dat[ST_CAUSE +: 4];
      end
      if (por_i) begin
         s_d.cause[CAUSE_POR] = 1'b1;
      end
      if (ext_rst_i) begin
         s_d.cause[CAUSE_EXT] = 1'b1;
      end
      if (sync_src & (wdog_timeout_i | clock_loss_i)) begin
         s_d.cause[CAUSE_WDOG] = 1'b1;
      end
      if (sync_src & s_q.sw_req) begin
         s_d.cause[CAUSE_SW] = 1'b1;
      end

      // bus slave: one wait cycle, any address answers
      s_d.ack = bus_go;
      if (bus_go & ~wb_req_i.we) begin
         s_d.rdat = '0;
         unique case (wb_req_i.adr)
            ADR_CTRL: begin
               s_d.rdat[CTRL_HSCLK] = s_q.hs_sel;
            end
            ADR_STOPDIS: begin
               s_d.rdat[NPER-1:0] = s_q.stop_dis;
            end
            ADR_CLKCFG: begin
               s_d.rdat[CFG_W-1:0] = s_q.cfg;
            end
            ADR_STATUS: begin
               s_d.rdat[ST_MODE +: 2]  = s_q.mode;
               s_d.rdat[ST_STBY]       = standby;
               s_d.rdat[ST_CGRST]      = s_q.cg_rst;
               s_d.rdat[ST_PERRST]     = s_q.per_rst;
               s_d.rdat[ST_CORERST]    = s_q.core_rst;
               s_d.rdat[ST_CAUSE +: 4] = s_q.cause;
            end
            default: begin
               s_d.rdat = '0;
            end
         endcase
      end

      // register writes; the device is held while combined is up
      if (combined) begin
         s_d.hs_sel   = 1'b0;
         s_d.stop_dis = '0;
         s_d.cfg      = '0;
      end else if (bus_wr) begin
         unique case (wb_req_i.adr)
            ADR_CTRL: begin
               s_d.hs_sel = wb_req_i.dat[CTRL_HSCLK];
               if (wb_req_i.dat[CTRL_SWRST] & ~s_q.sy_hold) begin
                  s_d.sw_req = 1'b1;
               end
            end
            ADR_STOPDIS: begin
               s_d.stop_dis = wb_req_i.dat[NPER-1:0];
            end
            ADR_CLKCFG: begin
               // ordering and pll lock wait are left to software
               s_d.cfg = wb_req_i.dat[CFG_W-1:0];
            end
            default: begin
               s_d.cfg = s_q.cfg;
            end
         endcase
      end
   end

   // ==========================================
   // registers; ce low freezes everything
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= STATE_RST;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // clock enables per mode
   always_comb begin
      // clock gen reset keeps everything below it unclocked
      periph_on = ~s_q.cg_rst &
                  ((s_q.mode == MODE_RUN) |
                   (s_q.mode == MODE_WAIT));
      core_clk_en_o   = ~s_q.cg_rst &
                        (s_q.mode == MODE_RUN);
      mem_clk_en_o    = core_clk_en_o;
      master_clk_en_o = (s_q.mode != MODE_PDOWN);
      for (int i = 0; i < NPER; i++) begin
         periph_clk_en_o[i] = periph_on |
                              (~s_q.cg_rst & (s_q.mode == MODE_STOP) &
                               s_q.stop_dis[i]);
      end
      // 3x clock exists only with the pll selected
      hs_clk_en_o = periph_on & s_q.hs_sel &
                    ~s_q.cfg[CFG_SRC] & ~s_q.cfg[CFG_PLL_POWER_DOWN];
   end

   // ==========================================
   // outputs
   assign wb_rsp_o.ack           = s_q.ack;
   assign wb_rsp_o.dat           = s_q.rdat;
   assign sys_tick_o             = s_q.sys_tick;
   assign wdog_tick_o            = s_q.wd_tick;
   assign clock_source_select_o  = s_q.cfg[CFG_SRC];
   assign pll_power_down_o       = s_q.cfg[CFG_PLL_POWER_DOWN];
   assign osc_standby_select_o   = s_q.cfg[CFG_OSCSB];
   assign regulator_standby_o    = s_q.cfg[CFG_REGSB];
   assign osc_power_down_o       = s_q.cfg[CFG_OSCPD];
   assign clock_gen_reset_out_o  = s_q.cg_rst;
   assign peripheral_reset_out_o = s_q.per_rst;
   assign core_reset_o           = s_q.core_rst;
   assign tap_reset_o            = s_q.por;
   assign wdog_logic_reset_o     = s_q.sy_hold;
   assign mode_o                 = s_q.mode;
   assign standby_o              = standby;

endmodule // pmrs_top

`default_nettype wire

//--- testbench/pmrs_chk.sv
// concurrent checks on the ports of the power mode and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module pmrs_chk
   import pmrs_pkg::*;
(
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   input wire logic                    ce_i,
   input wire logic                    osc_tick_i,
   input wire logic                    por_i,
   input wire logic                    ext_rst_i,
   input wire logic                    irq_any_i,
   input wire logic                    stop_irq_i,
   input wire logic                    lvi_irq_i,
   input wire logic                    debug_entry_i,
   input wire logic                    sys_tick_o,
   input wire logic                    wdog_tick_o,
   input wire logic                    master_clk_en_o,
   input wire logic                    core_clk_en_o,
   input wire logic                    mem_clk_en_o,
   input wire logic [pmrs_pkg::NPER-1:0] periph_clk_en_o,
   input wire logic                    clock_gen_reset_out_o,
   input wire logic                    peripheral_reset_out_o,
   input wire logic                    core_reset_o,
   input wire logic                    tap_reset_o,
   input wire logic                    wdog_logic_reset_o,
   input wire pmrs_pkg::pmrs_mode_e    mode_o
);
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // helper counts of ticks while a stage waits
   logic [6:0]  per_n_q, core_n_q;
   logic [10:0] osc_n_q;
   logic        wd_seen_q;
   // the watchdog span is only trusted after one full period with no reset in between
   always_ff @(posedge clk_i) begin
      per_n_q   <= (rst_i || clock_gen_reset_out_o) ? 7'h00 : per_n_q + 7'(peripheral_reset_out_o && sys_tick_o && ce_i);
      core_n_q  <= (rst_i || peripheral_reset_out_o) ? 7'h00 : core_n_q + 7'(core_reset_o && sys_tick_o && ce_i);
      // a tick frozen by ce low restarts the span only on the edge the design really takes
      osc_n_q   <= rst_i ? 11'h000 : ((wdog_tick_o && ce_i) ? 11'h000 : osc_n_q) + 11'(osc_tick_i && ce_i);
      wd_seen_q <= !rst_i && !wdog_logic_reset_o && (wd_seen_q || wdog_tick_o);
   end
   // ==========================================
   // assertions
   run_clk_a: assert property (mode_o == MODE_RUN && !clock_gen_reset_out_o |->
      core_clk_en_o && mem_clk_en_o && master_clk_en_o && &periph_clk_en_o) else $error("run clocks off");
   wait_gate_a: assert property (mode_o == MODE_WAIT |-> !core_clk_en_o && !mem_clk_en_o)
      else $error("core clock on in wait");
   wait_exit_a: assert property (ce_i && mode_o == MODE_WAIT && (irq_any_i || debug_entry_i)
      |=> mode_o == MODE_RUN) else $error("wait not left");
   stop_gate_a: assert property (mode_o == MODE_STOP |->
      master_clk_en_o && !core_clk_en_o && !mem_clk_en_o) else $error("stop gating wrong");
   stop_exit_a: assert property (ce_i && mode_o == MODE_STOP && (stop_irq_i || lvi_irq_i || debug_entry_i)
      |=> mode_o == MODE_RUN) else $error("stop not left");
   pdown_hold_a: assert property (mode_o == MODE_PDOWN && !por_i && !ext_rst_i |=>
      mode_o == MODE_PDOWN && !master_clk_en_o && !sys_tick_o) else $error("power down left");
   tap_por_a: assert property (ext_rst_i && !por_i && !$past(por_i) && !$past(rst_i) |-> !tap_reset_o)
      else $error("test port reset by ext");
   reset_all_a: assert property (ce_i && (por_i || ext_rst_i) |=>
      clock_gen_reset_out_o && peripheral_reset_out_o && core_reset_o) else $error("reset not staged");
   per_count_a: assert property ($fell(peripheral_reset_out_o) |-> per_n_q == 7'h20)
      else $error("peripheral release count");
   core_count_a: assert property ($fell(core_reset_o) |-> core_n_q == 7'h20 && !peripheral_reset_out_o)
      else $error("core release count");
   wdog_span_a: assert property (wdog_tick_o && wd_seen_q |-> osc_n_q == 11'h400)
      else $error("watchdog tick span");
endmodule // pmrs_chk
`default_nettype wire

//--- testbench/pmrs_core_mdl.sv
// behavioural processor core that issues wait and stop instructions
`timescale 1ns/10ps
`default_nettype none
module pmrs_core_mdl (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic core_reset_i,
   input  wire logic core_clk_en_i,
   input  wire logic do_wait_i,
   input  wire logic do_stop_i,
   output logic      wait_instr_o,
   output logic      stop_instr_o
);
   // a core held in reset or with its clock gated executes nothing
   always_ff @(posedge clk_i) begin
      wait_instr_o <= !rst_i && !core_reset_i && core_clk_en_i && do_wait_i;
      stop_instr_o <= !rst_i && !core_reset_i && core_clk_en_i && do_stop_i;
   end
endmodule // pmrs_core_mdl
`default_nettype wire

//--- testbench/pmrs_top_bench.sv
// self-checking bench of the power mode and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module pmrs_top_bench;
   import pmrs_pkg::*;
   // ==========================================
   // signals carry the port names so the instance connects by name
   logic         clk_i, rst_i, ce_i, osc_tick_i, mst_tick_i, ext_tick_i, por_i, ext_rst_i, standby_o;
   logic         wdog_timeout_i, clock_loss_i, wait_instr_i, stop_instr_i, irq_any_i, stop_irq_i;
   logic         lvi_irq_i, debug_entry_i, sys_tick_o, wdog_tick_o, master_clk_en_o, core_clk_en_o;
   logic         mem_clk_en_o, hs_clk_en_o, clock_source_select_o, pll_power_down_o, osc_standby_select_o;
   logic         regulator_standby_o, osc_power_down_o, clock_gen_reset_out_o, peripheral_reset_out_o;
   logic         core_reset_o, tap_reset_o, wdog_logic_reset_o, do_wait, do_stop;
   logic [7:0]   periph_clk_en_o;
   logic [31:0]  q;
   pmrs_mode_e   mode_o;
   pmrs_wb_req_s wb_req_i;
   pmrs_wb_rsp_s wb_rsp_o;
   int unsigned  ph, osc_n, sys_n, wd_n, b_osc, b_sys, b_wd, err_total, samples_checked;
   // instruction, wake sources {irq, stop irq, lvi, debug}, mode after each
   typedef struct packed {
      logic [1:0] ins;
      logic [3:0] wake;
      pmrs_mode_e mid;
      pmrs_mode_e fin;
   } pmrs_row_s;
   localparam pmrs_row_s ROWS [8] = '{
      '{2'h1, 4'h8, MODE_WAIT, MODE_RUN}, '{2'h1, 4'h1, MODE_WAIT, MODE_RUN},
      '{2'h1, 4'h4, MODE_WAIT, MODE_WAIT}, '{2'h2, 4'h4, MODE_STOP, MODE_RUN},
      '{2'h2, 4'h2, MODE_STOP, MODE_RUN}, '{2'h2, 4'h1, MODE_STOP, MODE_RUN},
      '{2'h2, 4'h8, MODE_STOP, MODE_STOP}, '{2'h3, 4'h1, MODE_STOP, MODE_RUN}};
   pmrs_top dut (.*);
   pmrs_core_mdl core (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .core_reset_i (core_reset_o),
      .core_clk_en_i(core_clk_en_o),
      .do_wait_i    (do_wait),
      .do_stop_i    (do_stop),
      .wait_instr_o (wait_instr_i),
      .stop_instr_o (stop_instr_i)
   );
   // ==========================================
   // clock, tick sources and tick counters
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // osc every 4, master every 2, external every 8 cycles; counts see what the design samples
   always @(posedge clk_i) begin
      ph         <= ph + 1;
      mst_tick_i <= ph[0];
      osc_tick_i <= ph[1:0] == 2'h3;
      ext_tick_i <= ph[2:0] == 3'h7;
      osc_n      <= osc_n + osc_tick_i;
      sys_n      <= sys_n + sys_tick_o;
      wd_n       <= wd_n + wdog_tick_o;
   end
   // ==========================================
   // tasks
   task automatic end_of_test();
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic fail_out();
      err_total++;
      end_of_test();
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one classic cycle, held until ack is sampled, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_req_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
      do begin
         @(posedge clk_i);
         n++;
         if (n > 20) fail_out();
      end while (wb_rsp_o.ack !== 1'b1);
      q = wb_rsp_o.dat;
      wb_req_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic mark();
      {b_osc, b_sys, b_wd} = {osc_n, sys_n, wd_n};
   endtask
   function automatic logic pick(int w);
      case (w)
         0: return clock_gen_reset_out_o;
         1: return peripheral_reset_out_o;
         2: return core_reset_o;
         default: return wdog_logic_reset_o;
      endcase
   endfunction
   task automatic wait_low(input int w, input int lim);
      for (int n = 0; pick(w) !== 1'b0; n++) begin
         if (n == lim) fail_out();
         @(posedge clk_i);
      end
   endtask
   task automatic release_chk(input int unsigned cg_osc);
      wait_low(0, 2000);
      chk("cg_osc", osc_n - b_osc, cg_osc);
      mark();
      wait_low(1, 400);
      chk("per_sys", sys_n - b_sys, 32);
      mark();
      wait_low(2, 400);
      chk("core_sys", sys_n - b_sys, 32);
   endtask
   task automatic pulse(input logic [1:0] ins, input logic [3:0] wk);
      {do_stop, do_wait} <= ins;
      {irq_any_i, stop_irq_i, lvi_irq_i, debug_entry_i} <= wk;
      @(posedge clk_i);
      {do_stop, do_wait} <= 2'h0;
      {irq_any_i, stop_irq_i, lvi_irq_i, debug_entry_i} <= 4'h0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic ext_pulse();
      ext_rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("core_ext", core_reset_o, 1);
      chk("tap_ext", tap_reset_o, 0);
      ext_rst_i <= 1'b0;
      @(posedge clk_i);
      mark();
   endtask
   // software steps into standby: source, pll off, oscillator standby, regulator last
   task automatic stby_in();
      for (int i = 1; i < 5; i++) wb(1'b1, ADR_CLKCFG, (32'h1 << i) - 1);
      chk("standby", standby_o, 1);
   endtask
   // ==========================================
   // main sequence
   initial begin
      {ce_i, rst_i, por_i, ext_rst_i} = 4'he;
      {wdog_timeout_i, clock_loss_i, irq_any_i, stop_irq_i, lvi_irq_i, debug_entry_i} = 6'h00;
      {do_wait, do_stop, wb_req_i} = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("tap_por", tap_reset_o, 1);
      por_i <= 1'b0;
      @(posedge clk_i);
      mark();
      wait_low(0, 2000);
      chk("cg_por", osc_n - b_osc, 96);
      ext_pulse();
      wait_low(3, 100);
      chk("wdl_osc", osc_n - b_osc, 3);
      release_chk(32);
      for (int s = 0; s < 3; s++) begin
         if (s == 0) wb(1'b1, ADR_CTRL, 32'h1);
         {clock_loss_i, wdog_timeout_i} <= s[1:0];
         @(posedge clk_i);
         {clock_loss_i, wdog_timeout_i} <= 2'h0;
         repeat (3) @(posedge clk_i);
         chk("cg_sync", clock_gen_reset_out_o, 1);
         wait_low(2, 2000);
      end
      wb(1'b0, ADR_CLKCFG, 0);
      chk("cfg_rst", q, 0);
      wb(1'b0, ADR_STATUS, 0);
      chk("cause", q, 32'hf00);
      wb(1'b1, ADR_STATUS, 32'hf00);
      wb(1'b0, 8'h10, 0);
      chk("unmapped", q, 0);
      wb(1'b0, ADR_STATUS, 0);
      chk("cause_clr", q, 0);
      wb(1'b1, ADR_STOPDIS, 32'h5a);
      wb(1'b1, ADR_CTRL, 32'h2);
      chk("hs_on", hs_clk_en_o, 1);
      mark();
      repeat (160) @(posedge clk_i);
      chk("run_sys", sys_n - b_sys, 40);
      foreach (ROWS[i]) begin
         pulse(ROWS[i].ins, 4'h0);
         chk("mode_mid", mode_o, ROWS[i].mid);
         if (ROWS[i].mid == MODE_STOP) chk("pce_stop", periph_clk_en_o, 32'h5a);
         pulse(2'h0, ROWS[i].wake);
         chk("mode_fin", mode_o, ROWS[i].fin);
         if (ROWS[i].fin != MODE_RUN) pulse(2'h0, 4'h1);
      end
      // ce low must swallow a wait instruction
      ce_i <= 1'b0;
      pulse(2'h1, 4'h0);
      chk("ce_hold", mode_o, MODE_RUN);
      ce_i <= 1'b1;
      stby_in();
      chk("hs_off", hs_clk_en_o, 0);
      wb(1'b1, ADR_CLKCFG, 32'h2f);
      mark();
      repeat (160) @(posedge clk_i);
      chk("ext_sys", sys_n - b_sys, 10);
      pulse(2'h1, 4'h0);
      chk("stby_wait", {standby_o, mode_o}, {1'b1, MODE_WAIT});
      pulse(2'h0, 4'h8);
      for (int i = 4; i > 0; i--) wb(1'b1, ADR_CLKCFG, (32'h1 << (i - 1)) - 1);
      chk("stby_off", standby_o, 0);
      stby_in();
      wb(1'b1, ADR_CLKCFG, 32'h1f);
      {wdog_timeout_i, clock_loss_i} <= 2'h3;
      pulse(2'h0, 4'hf);
      {wdog_timeout_i, clock_loss_i} <= 2'h0;
      chk("pdown", {master_clk_en_o, mode_o}, {1'b0, MODE_PDOWN});
      ext_pulse();
      wait_low(2, 2000);
      chk("pd_exit", mode_o, MODE_RUN);
      mark();
      repeat (8192) @(posedge clk_i);
      chk("wd_ticks", wd_n - b_wd, 2);
      end_of_test();
   end
endmodule // pmrs_top_bench
bind pmrs_top pmrs_chk u_chk (.*);
`default_nettype wire
